// >>> common/oja_params.svh
// Opcode map, field positions and reset values of the addressing and flow core.
// Assumes inclusion by the package and the design modules only.
`ifndef OJA_PARAMS_SVH
`define OJA_PARAMS_SVH

`define OJA_PC_RST 15'h0000
`define OJA_SP_RST 8'h6f
`define OJA_PTR_RST 8'h00
`define OJA_ACC_RST 8'h00

`define OJA_OP_NOP 8'h00
`define OJA_OP_JLONG 8'h30
`define OJA_OP_CALL 8'h31
`define OJA_OP_RET 8'h32
`define OJA_OP_JIND 8'h33
`define OJA_OP_TBLRD 8'h34
`define OJA_OP_VEC 8'h35
`define OJA_OP_PUSH 8'h36
`define OJA_OP_POP 8'h37
`define OJA_OP_PNDCLR 8'h38

`define OJA_REL_TAG 2'h3
`define OJA_GRP_ACC 4'h1
`define OJA_GRP_ABS 4'h2
`define OJA_GRP_IMM 4'h4
`define OJA_GRP_DIR 4'h5
`define OJA_GRP_BSI 4'h6
`define OJA_GRP_BIT 4'h7
`define OJA_GRP_IND_B 4'h8
`define OJA_GRP_IND_X 4'h9
`define OJA_GRP_STEP 4'ha

`define OJA_STEP_XCH_BIT 0
`define OJA_STEP_DN_BIT 1
`define OJA_STEP_X_BIT 2
`define OJA_BIT_SET_BIT 3

`define OJA_REL_BIAS 15'h001f
`define OJA_NIB_ZERO 4'h0
`define OJA_BCD_LO 8'h06
`define OJA_BCD_HI 8'h60
`define OJA_BCD_MAX 4'h9

`endif

// >>> common/oja_pkg.sv
// Types shared by the addressing and flow core and its helpers.
// Assumes oja_params.svh is on the include path.
`include "oja_params.svh"
package oja_pkg;
    typedef enum logic [2:0] {ST_FETCH, ST_BYTE2, ST_BYTE3, ST_EXEC, ST_VEC2, ST_CALL2, ST_RET2} oja_state_e;

    // Two-operand ops take the opcode low nibble; accumulator ops start at 5'h10
    typedef enum logic [4:0] {
        ALU_ADD = 5'h00, ALU_ADC = 5'h01, ALU_SUBTRACT_WITH_CARRY = 5'h02, ALU_AND = 5'h03, ALU_OR = 5'h04,
        ALU_XOR = 5'h05, ALU_LD = 5'h06, ALU_IFEQ = 5'h07, ALU_IFNE = 5'h08, ALU_IFGT = 5'h09,
        ALU_CLR = 5'h10, ALU_INC = 5'h11, ALU_DEC = 5'h12, ALU_DECIMAL_CORRECT = 5'h13, ALU_RRC = 5'h14,
        ALU_RLC = 5'h15, ALU_SWAP = 5'h16, ALU_SC = 5'h17, ALU_RC = 5'h18, ALU_IFC = 5'h19,
        ALU_IFNC = 5'h1a
    } oja_alu_e;
endpackage

// >>> common/oja_core_if.sv
// Bundles between the core sequencer and its arithmetic and jump helpers.
// Assumes everything is on one clock; both bundles are combinational.
interface oja_alu_if;
    import oja_pkg::*;
    oja_alu_e sel;
    logic [7:0] a;
    logic [7:0] b;
    logic c_in;
    logic hc_in;
    logic [7:0] y;
    logic c_out;
    logic hc_out;
    logic wr_acc;
    logic is_cond;
    logic cond;
    modport core (output sel, a, b, c_in, hc_in, input y, c_out, hc_out, wr_acc, is_cond, cond);
    modport unit (input sel, a, b, c_in, hc_in, output y, c_out, hc_out, wr_acc, is_cond, cond);
endinterface

interface oja_jmp_if;
    logic [7:0] op;
    logic [14:0] op_pc;
    logic [14:0] pc;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] pm_byte;
    logic [14:0] target;
    logic take;
    modport core (output op, op_pc, pc, b2, b3, pm_byte, input target, take);
    modport unit (input op, op_pc, pc, b2, b3, pm_byte, output target, take);
endinterface

// >>> rtl/oja_alu.sv
// Accumulator arithmetic, logic, rotate and compare unit.
// Assumes the sequencer decides whether a result is committed.
`include "oja_params.svh"
module oja_alu
    import oja_pkg::*;
(
    oja_alu_if.unit alu
);
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] fix;

    always_comb
    begin
        sum = 9'h000;
        low = 5'h00;
        fix = 8'h00;
        alu.y = alu.a;
        alu.c_out = alu.c_in;
        alu.hc_out = alu.hc_in;
        alu.wr_acc = 1'b1;
        alu.is_cond = 1'b0;
        alu.cond = 1'b1;
        case (alu.sel)
            ALU_ADD, ALU_ADC:
            begin
                sum = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, alu.sel == ALU_ADC && alu.c_in};
                low = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]} + {4'h0, alu.sel == ALU_ADC && alu.c_in};
                alu.y = sum[7:0];
                if (alu.sel == ALU_ADC)
                begin
                    alu.c_out = sum[8];
                    alu.hc_out = low[4];
                end
            end
            ALU_SUBTRACT_WITH_CARRY:
            begin
                // Carry set means no borrow
                sum = {1'b0, alu.a} + {1'b0, ~alu.b} + {8'h00, alu.c_in};
                low = {1'b0, alu.a[3:0]} + {1'b0, ~alu.b[3:0]} + {4'h0, alu.c_in};
                alu.y = sum[7:0];
                alu.c_out = sum[8];
                alu.hc_out = low[4];
            end
            ALU_AND: alu.y = alu.a & alu.b;
            ALU_OR: alu.y = alu.a | alu.b;
            ALU_XOR: alu.y = alu.a ^ alu.b;
            ALU_LD: alu.y = alu.b;
            ALU_IFEQ, ALU_IFNE, ALU_IFGT, ALU_IFC, ALU_IFNC:
            begin
                alu.wr_acc = 1'b0;
                alu.is_cond = 1'b1;
                case (alu.sel)
                    ALU_IFEQ: alu.cond = alu.a == alu.b;
                    ALU_IFNE: alu.cond = alu.a != alu.b;
                    ALU_IFGT: alu.cond = alu.a > alu.b;
                    ALU_IFC: alu.cond = alu.c_in;
                    default: alu.cond = !alu.c_in;
                endcase
            end
            ALU_CLR: alu.y = 8'h00;
            ALU_INC: alu.y = alu.a + 8'h01;
            ALU_DEC: alu.y = alu.a - 8'h01;
            ALU_DECIMAL_CORRECT:
            begin
                fix = (alu.hc_in || alu.a[3:0] > `OJA_BCD_MAX) ? `OJA_BCD_LO : 8'h00;
                fix = fix | ((alu.c_in || alu.a[7:4] > `OJA_BCD_MAX) ? `OJA_BCD_HI : 8'h00);
                sum = {1'b0, alu.a} + {1'b0, fix};
                alu.y = sum[7:0];
                alu.c_out = alu.c_in | sum[8];
            end
            ALU_RRC:
            begin
                alu.y = {alu.c_in, alu.a[7:1]};
                alu.c_out = alu.a[0];
            end
            ALU_RLC:
            begin
                alu.y = {alu.a[6:0], alu.c_in};
                alu.c_out = alu.a[7];
                alu.hc_out = alu.a[0];
            end
            ALU_SWAP: alu.y = {alu.a[3:0], alu.a[7:4]};
            ALU_SC, ALU_RC:
            begin
                alu.wr_acc = 1'b0;
                alu.c_out = alu.sel == ALU_SC;
                alu.hc_out = alu.sel == ALU_SC;
            end
            default: alu.wr_acc = 1'b0;
        endcase
    end
endmodule

// >>> rtl/oja_jmp.sv
// Jump target former for relative, absolute, long and indirect transfers.
// Assumes op, operand bytes and the table byte are stable during execute.
`include "oja_params.svh"
module oja_jmp
    import oja_pkg::*;
(
    oja_jmp_if.unit jmp
);
    always_comb
    begin
        jmp.take = 1'b1;
        jmp.target = jmp.pc;
        if (jmp.op[7:6] == `OJA_REL_TAG)
            // Distance field 0..63 maps onto -31..+32 from the opcode address
            jmp.target = jmp.op_pc + {9'h000, jmp.op[5:0]} - `OJA_REL_BIAS;
        else if (jmp.op[7:4] == `OJA_GRP_ABS)
            jmp.target = {jmp.op_pc[14:12], jmp.op[3:0], jmp.b2};
        else if (jmp.op == `OJA_OP_JLONG || jmp.op == `OJA_OP_CALL)
        begin
            jmp.target = {jmp.b2[6:0], jmp.b3};
            jmp.take = jmp.op == `OJA_OP_JLONG;
        end
        else if (jmp.op == `OJA_OP_JIND)
            jmp.target = {jmp.pc[14:8], jmp.pm_byte};
        else
            jmp.take = 1'b0;
    end
endmodule

// >>> rtl/oja_core.sv
// Instruction sequencer: operand addressing, program flow, skip and stack handling.
// Assumes program and data memories answer combinationally to the registered addresses,
// and data memory writes at the clock edge that ends a cycle with DATA_WE high.
`include "oja_params.svh"

module oja_core
    import oja_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // Program memory
    output logic [14:0] PROG_ADDR,
    input wire logic [7:0] PROG_DATA,
    // Data memory
    output logic [7:0] DATA_ADDR,
    output logic [7:0] DATA_WDATA,
    output logic DATA_WE,
    input wire logic [7:0] DATA_RDATA,
    // Interrupt controller
    input wire logic [14:0] VEC_ADDR,
    output logic PEND_CLR,
    // Observation
    output logic [14:0] PC_OUT,
    output logic [7:0] ACC_OUT,
    output logic CARRY_OUT,
    output logic [7:0] PTR_B_OUT,
    output logic [7:0] PTR_X_OUT,
    output logic [7:0] SP_OUT,
    output logic SKIP_OUT
);
    oja_state_e st, next_st;
    logic [14:0] pc, next_pc;
    logic [14:0] op_pc, next_op_pc;
    logic [7:0] op, next_op;
    logic [7:0] b2, next_b2;
    logic [7:0] b3, next_b3;
    logic [7:0] acc, next_acc;
    logic carry, next_carry;
    logic hcarry, next_hcarry;
    logic [7:0] ptr_b, next_ptr_b;
    logic [7:0] ptr_x, next_ptr_x;
    logic [7:0] sp, next_sp;
    logic skip, next_skip;
    logic [6:0] hi_hold, next_hi_hold;
    logic [14:0] pm_addr, next_pm_addr;
    logic [7:0] dm_addr, next_dm_addr;
    logic [7:0] dm_wdata, next_dm_wdata;
    logic dm_we, next_dm_we;
    logic pend_clr, next_pend_clr;
    logic [14:0] pc_inc;
    logic [3:0] grp;
    logic step_x;

    oja_alu_if alu_bus ();
    oja_jmp_if jmp_bus ();

    oja_alu u_alu (
        .alu(alu_bus.unit)
    );

    oja_jmp u_jmp (
        .jmp(jmp_bus.unit)
    );

    // Instruction length in bytes; used to plan operand fetches
    function automatic logic [1:0] oja_len(input logic [7:0] code);
        if (code == `OJA_OP_JLONG || code == `OJA_OP_CALL)
            return 2'd3;
        else if (code[7:6] != `OJA_REL_TAG && (code[7:4] == `OJA_GRP_ABS || code[7:4] == `OJA_GRP_IMM
                 || code[7:4] == `OJA_GRP_DIR || code[7:4] == `OJA_GRP_BIT))
            return 2'd2;
        else
            return 2'd1;
    endfunction

    assign pc_inc = pc + 15'h0001;
    assign grp = op[7:4];
    assign step_x = op[`OJA_STEP_X_BIT];

    assign alu_bus.core.sel = oja_alu_e'({grp == `OJA_GRP_ACC, op[3:0]});
    assign alu_bus.core.a = acc;
    assign alu_bus.core.b = (grp == `OJA_GRP_IMM) ? b2 : DATA_RDATA;
    assign alu_bus.core.c_in = carry;
    assign alu_bus.core.hc_in = hcarry;

    assign jmp_bus.core.op = op;
    assign jmp_bus.core.op_pc = op_pc;
    assign jmp_bus.core.pc = pc;
    assign jmp_bus.core.b2 = b2;
    assign jmp_bus.core.b3 = b3;
    assign jmp_bus.core.pm_byte = PROG_DATA;

    always_comb
    begin
        next_st = st;
        next_pc = pc;
        next_op_pc = op_pc;
        next_op = op;
        next_b2 = b2;
        next_b3 = b3;
        next_acc = acc;
        next_carry = carry;
        next_hcarry = hcarry;
        next_ptr_b = ptr_b;
        next_ptr_x = ptr_x;
        next_sp = sp;
        next_skip = skip;
        next_hi_hold = hi_hold;
        next_pm_addr = pm_addr;
        next_dm_addr = dm_addr;
        next_dm_wdata = dm_wdata;
        next_dm_we = 1'b0;
        next_pend_clr = 1'b0;
        case (st)
            ST_FETCH:
            begin
                next_op = PROG_DATA;
                next_op_pc = pc;
                next_pc = pc_inc;
                next_pm_addr = pc_inc;
                next_st = (oja_len(PROG_DATA) == 2'd1) ? ST_EXEC : ST_BYTE2;
                // Table reads point at the upper byte of the address after the opcode, with the accumulator low
                if (PROG_DATA == `OJA_OP_TBLRD || PROG_DATA == `OJA_OP_JIND)
                    next_pm_addr = {pc_inc[14:8], acc};
                else if (PROG_DATA == `OJA_OP_VEC)
                    next_pm_addr = VEC_ADDR;
                if (PROG_DATA[7:6] != `OJA_REL_TAG)
                begin
                    if (PROG_DATA[7:4] == `OJA_GRP_IND_B
                        || (PROG_DATA[7:4] == `OJA_GRP_STEP && !PROG_DATA[`OJA_STEP_X_BIT]))
                        next_dm_addr = ptr_b;
                    else if (PROG_DATA[7:4] == `OJA_GRP_IND_X || PROG_DATA[7:4] == `OJA_GRP_STEP)
                        next_dm_addr = ptr_x;
                    else if (PROG_DATA == `OJA_OP_POP || PROG_DATA == `OJA_OP_RET)
                        next_dm_addr = sp + 8'h01;
                end
            end
            ST_BYTE2:
            begin
                next_b2 = PROG_DATA;
                next_pc = pc_inc;
                next_pm_addr = pc_inc;
                if (grp == `OJA_GRP_DIR || grp == `OJA_GRP_BIT)
                    next_dm_addr = PROG_DATA;
                next_st = (oja_len(op) == 2'd3) ? ST_BYTE3 : ST_EXEC;
            end
            ST_BYTE3:
            begin
                next_b3 = PROG_DATA;
                next_pc = pc_inc;
                next_pm_addr = pc_inc;
                next_st = ST_EXEC;
            end
            ST_EXEC:
            begin
                next_st = ST_FETCH;
                next_pm_addr = pc;
                if (skip)
                    // Operand bytes were consumed above; only the commit is dropped
                    next_skip = 1'b0;
                else if (jmp_bus.core.take)
                begin
                    next_pc = jmp_bus.core.target;
                    next_pm_addr = jmp_bus.core.target;
                end
                else if (op == `OJA_OP_TBLRD)
                    next_acc = PROG_DATA;
                else if (op == `OJA_OP_VEC)
                begin
                    next_hi_hold = PROG_DATA[6:0];
                    next_pm_addr = pm_addr + 15'h0001;
                    next_st = ST_VEC2;
                end
                else if (op == `OJA_OP_CALL)
                begin
                    next_dm_we = 1'b1;
                    next_dm_addr = sp;
                    next_dm_wdata = pc[7:0];
                    next_st = ST_CALL2;
                end
                else if (op == `OJA_OP_RET)
                begin
                    next_hi_hold = DATA_RDATA[6:0];
                    next_dm_addr = sp + 8'h02;
                    next_st = ST_RET2;
                end
                else if (op == `OJA_OP_PUSH)
                begin
                    next_dm_we = 1'b1;
                    next_dm_addr = sp;
                    next_dm_wdata = acc;
                    next_sp = sp - 8'h01;
                end
                else if (op == `OJA_OP_POP)
                begin
                    next_acc = DATA_RDATA;
                    next_sp = sp + 8'h01;
                end
                else if (op == `OJA_OP_PNDCLR)
                    next_pend_clr = 1'b1;
                else if (grp == `OJA_GRP_BSI)
                    next_ptr_b = {`OJA_NIB_ZERO, op[3:0]};
                else if (grp == `OJA_GRP_BIT)
                begin
                    next_dm_we = 1'b1;
                    next_dm_wdata = op[`OJA_BIT_SET_BIT] ? (DATA_RDATA | (8'h01 << op[2:0]))
                                                        : (DATA_RDATA & ~(8'h01 << op[2:0]));
                end
                else if (grp == `OJA_GRP_STEP)
                begin
                    next_acc = DATA_RDATA;
                    if (op[`OJA_STEP_XCH_BIT])
                    begin
                        next_dm_we = 1'b1;
                        next_dm_wdata = acc;
                    end
                    if (step_x)
                        next_ptr_x = op[`OJA_STEP_DN_BIT] ? ptr_x - 8'h01 : ptr_x + 8'h01;
                    else
                        next_ptr_b = op[`OJA_STEP_DN_BIT] ? ptr_b - 8'h01 : ptr_b + 8'h01;
                end
                else if (grp == `OJA_GRP_ACC || grp == `OJA_GRP_IMM || grp == `OJA_GRP_DIR
                         || grp == `OJA_GRP_IND_B || grp == `OJA_GRP_IND_X)
                begin
                    if (alu_bus.core.wr_acc)
                        next_acc = alu_bus.core.y;
                    next_carry = alu_bus.core.c_out;
                    next_hcarry = alu_bus.core.hc_out;
                    if (alu_bus.core.is_cond)
                        next_skip = !alu_bus.core.cond;
                end
                // Anything else, the no-operation included, leaves all state alone
            end
            ST_VEC2:
            begin
                // Bit 7 of the upper vector byte is dropped to fit the 15-bit counter
                next_pc = {hi_hold, PROG_DATA};
                next_pm_addr = {hi_hold, PROG_DATA};
                next_st = ST_FETCH;
            end
            ST_CALL2:
            begin
                next_dm_we = 1'b1;
                next_dm_addr = sp - 8'h01;
                next_dm_wdata = {1'b0, pc[14:8]};
                next_sp = sp - 8'h02;
                next_pc = jmp_bus.core.target;
                next_pm_addr = jmp_bus.core.target;
                next_st = ST_FETCH;
            end
            ST_RET2:
            begin
                next_pc = {hi_hold, DATA_RDATA};
                next_pm_addr = {hi_hold, DATA_RDATA};
                next_sp = sp + 8'h02;
                next_st = ST_FETCH;
            end
            default: next_st = ST_FETCH;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            st <= ST_FETCH;
            pc <= `OJA_PC_RST;
            op_pc <= `OJA_PC_RST;
            op <= `OJA_OP_NOP;
            b2 <= 8'h00;
            b3 <= 8'h00;
            acc <= `OJA_ACC_RST;
            carry <= 1'b0;
            hcarry <= 1'b0;
            ptr_b <= `OJA_PTR_RST;
            ptr_x <= `OJA_PTR_RST;
            sp <= `OJA_SP_RST;
            skip <= 1'b0;
            hi_hold <= 7'h00;
            pm_addr <= `OJA_PC_RST;
            dm_addr <= 8'h00;
            dm_wdata <= 8'h00;
            dm_we <= 1'b0;
            pend_clr <= 1'b0;
        end
        else
        begin
            st <= next_st;
            pc <= next_pc;
            op_pc <= next_op_pc;
            op <= next_op;
            b2 <= next_b2;
            b3 <= next_b3;
            acc <= next_acc;
            carry <= next_carry;
            hcarry <= next_hcarry;
            ptr_b <= next_ptr_b;
            ptr_x <= next_ptr_x;
            sp <= next_sp;
            skip <= next_skip;
            hi_hold <= next_hi_hold;
            pm_addr <= next_pm_addr;
            dm_addr <= next_dm_addr;
            dm_wdata <= next_dm_wdata;
            dm_we <= next_dm_we;
            pend_clr <= next_pend_clr;
        end
    end

    assign PROG_ADDR = pm_addr;
    assign DATA_ADDR = dm_addr;
    assign DATA_WDATA = dm_wdata;
    assign DATA_WE = dm_we;
    assign PEND_CLR = pend_clr;
    assign PC_OUT = pc;
    assign ACC_OUT = acc;
    assign CARRY_OUT = carry;
    assign PTR_B_OUT = ptr_b;
    assign PTR_X_OUT = ptr_x;
    assign SP_OUT = sp;
    assign SKIP_OUT = skip;
endmodule

// >>> tb/oja_core_assertions.sv
// Port checks for the addressing and flow core: stack pairing, pointer steps, pulses.
// Assumes it is bound to oja_core and sees only its ports.
module oja_core_assertions (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // Watched outputs
    input wire logic [7:0] DATA_ADDR,
    input wire logic DATA_WE,
    input wire logic PEND_CLR,
    input wire logic [7:0] ACC_OUT,
    input wire logic CARRY_OUT,
    input wire logic [7:0] PTR_B_OUT,
    input wire logic [7:0] PTR_X_OUT,
    input wire logic [7:0] SP_OUT,
    input wire logic SKIP_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    // Only a call writes in two cycles running
    sequence s_two_wr;
        DATA_WE ##1 DATA_WE;
    endsequence
    property p_call_pair;
        s_two_wr |-> DATA_ADDR == $past(DATA_ADDR) - 8'h01;
    endproperty
    a_call_pair: assert property (p_call_pair) else $error("call push pair not adjacent");
    property p_we_max;
        s_two_wr |=> !DATA_WE;
    endproperty
    a_we_max: assert property (p_we_max) else $error("more than two writes in a row");
    property p_sp_step;
        $changed(SP_OUT) |-> 8'(SP_OUT - $past(SP_OUT)) inside {8'h01, 8'h02, 8'hff, 8'hfe};
    endproperty
    a_sp_step: assert property (p_sp_step) else $error("stack pointer jumped");
    property p_b_step;
        $changed(PTR_B_OUT) |-> 8'(PTR_B_OUT - $past(PTR_B_OUT)) inside {8'h01, 8'hff} || PTR_B_OUT[7:4] == 4'h0;
    endproperty
    a_b_step: assert property (p_b_step) else $error("B pointer bad change");
    property p_x_step;
        $changed(PTR_X_OUT) |-> 8'(PTR_X_OUT - $past(PTR_X_OUT)) inside {8'h01, 8'hff};
    endproperty
    a_x_step: assert property (p_x_step) else $error("X pointer bad change");
    property p_pend_pulse;
        PEND_CLR |=> !PEND_CLR;
    endproperty
    a_pend_pulse: assert property (p_pend_pulse) else $error("pending clear too long");
    property p_pend_quiet;
        PEND_CLR |-> !DATA_WE;
    endproperty
    a_pend_quiet: assert property (p_pend_quiet) else $error("pending clear wrote memory");
    property p_we_quiet;
        DATA_WE |=> $stable(ACC_OUT) && $stable(CARRY_OUT);
    endproperty
    a_we_quiet: assert property (p_we_quiet) else $error("accumulator moved in write cycle");
    // A skipped instruction still runs its fetch and execute cycles but commits nothing
    property p_skip_quiet;
        SKIP_OUT |=> !DATA_WE && $stable(ACC_OUT) && $stable(CARRY_OUT) && $stable(PTR_B_OUT)
            && $stable(PTR_X_OUT) && $stable(SP_OUT);
    endproperty
    a_skip_quiet: assert property (p_skip_quiet) else $error("skipped instruction changed state");
endmodule

bind oja_core oja_core_assertions oja_core_assertions_i (.REF_CLK, .ARST_N, .DATA_ADDR, .DATA_WE, .PEND_CLR,
    .ACC_OUT, .CARRY_OUT, .PTR_B_OUT, .PTR_X_OUT, .SP_OUT, .SKIP_OUT);

// >>> tb/oja_mem.sv
// Program and data memory model answering the core combinationally.
// Assumes the bench loads rom and ram directly while the core is in reset.
module oja_mem (
    // Clock
    input wire logic clk,
    // Program side
    input wire logic [14:0] prog_addr,
    output logic [7:0] prog_data,
    // Data side
    input wire logic [7:0] data_addr,
    input wire logic [7:0] data_wdata,
    input wire logic data_we,
    output logic [7:0] data_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rom [32768];
    logic [7:0] ram [256];
    assign prog_data = rom[prog_addr];
    assign data_rdata = ram[data_addr];
    always @(posedge clk)
    begin
        if (data_we === 1'b1)
            ram[data_addr] <= data_wdata;
    end
endmodule

// >>> tb/oja_core_tb.sv
// Self-checking bench: small programs run from reset, final state compared.
// Assumes oja_mem stands in for both memories; programs end in a jump to self.
module oja_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, arst_n = 1'b0, data_we, pend_clr, carry, skip;
    logic [14:0] prog_addr, pc, vec_addr = 15'h0100;
    logic [7:0] prog_data, data_addr, data_wdata, data_rdata, acc, ptr_b, ptr_x, sp;
    int error_cnt = 0, checked = 0, cycles = 0, pend_cnt = 0;
    oja_mem oja_mem_i (.clk(ref_clk), .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
        .data_wdata(data_wdata), .data_we(data_we), .data_rdata(data_rdata));
    oja_core oja_core_i (.REF_CLK(ref_clk), .ARST_N(arst_n), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
        .DATA_ADDR(data_addr), .DATA_WDATA(data_wdata), .DATA_WE(data_we), .DATA_RDATA(data_rdata),
        .VEC_ADDR(vec_addr), .PEND_CLR(pend_clr), .PC_OUT(pc), .ACC_OUT(acc), .CARRY_OUT(carry),
        .PTR_B_OUT(ptr_b), .PTR_X_OUT(ptr_x), .SP_OUT(sp), .SKIP_OUT(skip));
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (pend_clr === 1'b1)
            pend_cnt++;
        if (cycles == 2000)
        begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [14:0] got, input logic [14:0] exp);
        checked++;
        if (got !== exp)
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            error_cnt++;
    endtask
    task automatic put(input int a, input logic [7:0] p[$]);
        foreach (p[i])
            oja_mem_i.rom[a + i] = p[i];
    endtask
    // Clears both memories under reset; the program is placed afterwards
    task automatic clear();
        @(posedge ref_clk);
        #1 arst_n = 1'b0;
        foreach (oja_mem_i.rom[i])
            oja_mem_i.rom[i] = 8'h00;
        foreach (oja_mem_i.ram[i])
            oja_mem_i.ram[i] = 8'h00;
    endtask
    // Reset for 10 cycles, then run long enough to reach the closing self-jump
    task automatic go();
        repeat (10) @(posedge ref_clk);
        #1 arst_n = 1'b1;
        repeat (80) @(posedge ref_clk);
        #1;
        // The closing self-jump alternates fetch and execute; compare in its fetch cycle
        if (prog_data !== 8'hdf)
        begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    task automatic t_operands();
        clear();
        put(0, '{8'h6c, 8'ha0, 8'h46, 8'ha5, 8'ha1, 8'h56, 8'h20, 8'ha7, 8'hdf});
        oja_mem_i.ram[8'h0c] = 8'h11;
        oja_mem_i.ram[8'h0d] = 8'h22;
        oja_mem_i.ram[8'h20] = 8'h33;
        oja_mem_i.ram[8'h00] = 8'h44;
        go();
        chk(15'(oja_mem_i.ram[8'h0d]), 15'h00a5);
        chk(15'(oja_mem_i.ram[8'h00]), 15'h0033);
        chk(15'(acc), 15'h0044);
        chk(15'(ptr_b), 15'h000e);
        chk(15'(ptr_x), 15'h00ff);
        $display("test operands done");
    endtask
    task automatic t_jumps();
        clear();
        put(0, '{8'h30, 8'h12, 8'h34});
        put(15'h1234, '{8'h46, 8'h80, 8'h34, 8'hc0}); // relative distance 0 lands 31 back
        put(15'h1280, '{8'h5a});
        put(15'h1218, '{8'h2f, 8'hff});
        put(15'h1fff, '{8'h33});
        put(15'h205a, '{8'h40});
        put(15'h2040, '{8'hdf});
        go();
        chk(pc, 15'h2040);
        chk(15'(acc), 15'h005a);
        $display("test jumps done");
    endtask
    task automatic t_stack();
        clear();
        put(0, '{8'h31, 8'h00, 8'h40, 8'h35});
        put(15'h0040, '{8'h46, 8'h77, 8'h36, 8'h38, 8'h10, 8'h37, 8'h32});
        put(15'h0100, '{8'h05, 8'h50});
        put(15'h0550, '{8'h7b, 8'h30, 8'h72, 8'h30, 8'hdf});
        oja_mem_i.ram[8'h30] = 8'h04;
        pend_cnt = 0;
        go();
        chk(15'(oja_mem_i.ram[8'h6f]), 15'h0003);
        chk(15'(oja_mem_i.ram[8'h6e]), 15'h0000);
        chk(15'(oja_mem_i.ram[8'h6d]), 15'h0077);
        chk(15'(sp), 15'h006f);
        chk(15'(acc), 15'h0077);
        chk(pc, 15'h0554);
        chk(15'(pend_cnt), 15'h0001);
        chk(15'(oja_mem_i.ram[8'h30]), 15'h0008);
        $display("test stack done");
    endtask
    task automatic t_alu_skip();
        clear();
        put(0, '{8'h46, 8'h0f, 8'h45, 8'hff, 8'h17, 8'h14, 8'h19, 8'h46, 8'h33, 8'h1a, 8'h11, 8'h16, 8'h12,
            8'h00, 8'hdf});
        go();
        chk(15'(acc), 15'h009e);
        chk(15'(carry), 15'h0000);
        chk(pc, 15'h000e);
        $display("test alu and skip done");
    endtask
    // Carry arithmetic, decimal fix, compares with skips, and plain [B] and [X] operands
    task automatic t_arith();
        clear();
        put(0, '{8'h46, 8'h38, 8'h17, 8'h41, 8'h49, 8'h13, 8'h17, 8'h42, 8'h25, 8'h40, 8'h10, 8'h15, 8'h43,
            8'h8f, 8'h44, 8'h30, 8'h47, 8'hb7, 8'h11, 8'h48, 8'hb8, 8'h10, 8'h49, 8'hc0, 8'h12, 8'h65, 8'h80,
            8'h91, 8'hdf});
        oja_mem_i.ram[8'h05] = 8'h21;
        oja_mem_i.ram[8'h00] = 8'h30;
        go();
        chk(15'(acc), 15'h0009);
        chk(15'(carry), 15'h0001);
        chk(15'(ptr_b), 15'h0005);
        chk(pc, 15'h001c);
        $display("test arithmetic done");
    endtask
    initial
    begin
        t_operands();
        t_jumps();
        t_stack();
        t_alu_skip();
        t_arith();
        conclude();
    end
endmodule
